// >>> logic/tsrs_pkg.sv
// Register map, field positions and timing constants of the temperature sensor register bank
package tsrs_pkg;
    // Register pointer values
    localparam logic [7:0]  PTR_CAP       = 8'h00;
    localparam logic [7:0]  PTR_CFG       = 8'h01;
    localparam logic [7:0]  PTR_UPPER     = 8'h02;
    localparam logic [7:0]  PTR_LOWER     = 8'h03;
    localparam logic [7:0]  PTR_CRIT      = 8'h04;
    localparam logic [7:0]  PTR_AMB       = 8'h05;
    localparam logic [7:0]  PTR_MAKER     = 8'h06;
    localparam logic [7:0]  PTR_PART      = 8'h08;
    localparam logic [7:0]  PTR_RES       = 8'h09;
    // Configuration fields
    localparam int          CFG_SHDN_BIT  = 8;
    localparam int          CFG_LOCK_CRIT = 7;
    localparam int          CFG_LOCK_WIN  = 6;
    localparam int          CFG_EVT_STAT  = 4;
    localparam int          CFG_EVT_EN    = 3;
    localparam int          CFG_EVT_POL   = 1;
    localparam logic [15:0] CFG_WMASK     = 16'h06CF;
    localparam logic [15:0] CFG_RESET     = 16'h0000;
    // Limit, resolution and capability fields
    localparam logic [15:0] LIM_MASK      = 16'h1FFC;
    localparam logic [1:0]  RES_RESET     = 2'h1;
    localparam logic [15:0] CAP_BASE      = 16'h00E7;
    localparam int          CAP_RES_LSB   = 3;
    // Ambient word fields
    localparam int          AMB_CRIT_BIT  = 15;
    localparam int          AMB_UPPER_BIT = 14;
    localparam int          AMB_LOWER_BIT = 13;
    localparam int          AMB_SIGN_BIT  = 12;
    localparam int          TEMP_W        = 13;
    // Conversion periods in ms, per resolution code 0..3
    localparam int          CLK_KHZ       = 200000;
    localparam int          CONV_MS_0     = 30;
    localparam int          CONV_MS_1     = 65;
    localparam int          CONV_MS_2     = 130;
    localparam int          CONV_MS_3     = 260;
    localparam int          CONV_CYC_0    = CONV_MS_0 * CLK_KHZ;
    localparam int          CONV_CYC_1    = CONV_MS_1 * CLK_KHZ;
    localparam int          CONV_CYC_2    = CONV_MS_2 * CLK_KHZ;
    localparam int          CONV_CYC_3    = CONV_MS_3 * CLK_KHZ;
    localparam int          TIMER_W       = 26;
    // Serial engine states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_AACK  = 3'h2,
        ST_WBYTE = 3'h3,
        ST_WACK  = 3'h4,
        ST_RBYTE = 3'h5,
        ST_RACK  = 3'h6
    } tsrs_state_e;
endpackage : tsrs_pkg

// >>> logic/tsrs_core.sv
// Temperature sensor register bank behind a two-wire serial slave
// Operation
// [R1] Host reads ambient: pointer 05, repeated start, two bytes
// [R2] Ambient high byte: three flags, then sign
// [R3] Magnitude is high*16 plus low/16 format
// [R4] Pointer persists between transactions
// [R5] Read-only 16-bit maker identity word
// [R6] Pointer 08: part code and revision
// [R7] Resolution bits 1-0 choose step, rest zero
// [R8] Conversion period follows resolution; reset 0.25C
// [R9] Capability register mirrors active resolution
// [R10] Resolution changes only during shutdown
// [R11] Config bit 8 enters shutdown, stops sampling
// [R12] Shutdown holds until bit cleared or reset
// [R13] Shutdown cannot be set while locked
// [R14] Shutdown may be cleared while locked
// [R15] All registers accessible during shutdown
// [R16] Alert released and held off in shutdown
// [R17] Alert waits one conversion after shutdown
// [R18] Capability bits 4-3 show resolution
// [R19] Limits unchangeable while either lock set
// [R20] Resolution write outside shutdown is ignored
// [R21] Identity writes acknowledged, contents unchanged
module tsrs_core
    import tsrs_pkg::*;
#(
    parameter logic [6:0]  DEV_ADDR  = 7'h18,
    parameter logic [15:0] MAKER_ID  = 16'h1A2B, // Arbitrary value
    parameter logic [7:0]  PART_ID   = 8'h5A,    // Arbitrary value
    parameter logic [7:0]  REV_ID    = 8'h11,    // Arbitrary value
    parameter int          CONV0_CYC = tsrs_pkg::CONV_CYC_0,
    parameter int          CONV1_CYC = tsrs_pkg::CONV_CYC_1,
    parameter int          CONV2_CYC = tsrs_pkg::CONV_CYC_2,
    parameter int          CONV3_CYC = tsrs_pkg::CONV_CYC_3
) (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        scl_in,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe,
    input  wire logic [tsrs_pkg::TEMP_W-1:0] temp_code,
    output logic                             event_out,
    output logic                             sampling_en
);
    import tsrs_pkg::*;

    initial begin
        if (CONV0_CYC < 2 || CONV1_CYC < 2 || CONV2_CYC < 2 || CONV3_CYC < 2 ||
            CONV3_CYC >= (1 << TIMER_W))
            $error("tsrs_core: conversion counts out of range");
    end

    // Two-flop synchronisers, third stage only for edge detection
    logic [1:0]        scl_sync;
    logic [1:0]        sda_sync;
    logic              scl_d;
    logic              sda_d;
    logic [TEMP_W-1:0] temp_s1;
    logic [TEMP_W-1:0] temp_s2;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
            temp_s1  <= 13'h0000;
            temp_s2  <= 13'h0000;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
            temp_s1  <= temp_code;
            temp_s2  <= temp_s1;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise  = scl_sync[1] && !scl_d;
    assign scl_fall  = !scl_sync[1] && scl_d;
    assign bus_start = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
    assign bus_stop  = scl_sync[1] && scl_d && !sda_d && sda_sync[1];

    // Register state
    logic [15:0]       cfg_reg;
    logic [15:0]       upper_reg;
    logic [15:0]       lower_reg;
    logic [15:0]       crit_reg;
    logic [1:0]        res_reg;
    logic [TEMP_W-1:0] amb_reg;
    logic              valid_reg;
    logic [7:0]        ptr_reg;
    logic              wr_pulse_reg;
    logic [15:0]       wr_word_reg;
    logic              shutdown;
    logic              locked;
    logic              event_active;
    assign shutdown = cfg_reg[CFG_SHDN_BIT];
    assign locked   = cfg_reg[CFG_LOCK_CRIT] || cfg_reg[CFG_LOCK_WIN];

    // Limit flags from the latest result; limits share the ambient scaling
    logic flag_crit;
    logic flag_upper;
    logic flag_lower;
    assign flag_crit  = $signed(amb_reg) >= $signed(crit_reg[TEMP_W-1:0]); // R2
    assign flag_upper = $signed(amb_reg) > $signed(upper_reg[TEMP_W-1:0]);
    assign flag_lower = $signed(amb_reg) < $signed(lower_reg[TEMP_W-1:0]);

    // Word seen by the host for a given pointer; unmapped pointers read zero
    function automatic logic [15:0] read_word(input logic [7:0] p);
        logic [15:0] w;
        w = 16'h0000;
        case (p)
            PTR_CAP:   w = CAP_BASE | (16'(res_reg) << CAP_RES_LSB); // R9 R18
            PTR_CFG:   w = cfg_reg | (16'(event_active) << CFG_EVT_STAT);
            PTR_UPPER: w = upper_reg;
            PTR_LOWER: w = lower_reg;
            PTR_CRIT:  w = crit_reg;
            PTR_AMB:   w = {flag_crit, flag_upper, flag_lower, amb_reg}; // R2 R3
            PTR_MAKER: w = MAKER_ID; // R5
            PTR_PART:  w = {PART_ID, REV_ID}; // R6
            PTR_RES:   w = {14'h0000, res_reg}; // R7
            default:   w = 16'h0000;
        endcase
        return w;
    endfunction : read_word

    // Word for the current pointer; capability word kept for its mirror check
    logic [15:0] rd_now;
    logic [15:0] cap_now;
    always_comb begin
        rd_now  = read_word(ptr_reg);
        cap_now = read_word(PTR_CAP);
    end

    // Serial slave engine; samples on SCL rise, drives on SCL fall
    tsrs_state_e state_reg;
    logic [3:0]  bit_cnt_reg;
    logic [7:0]  shift_reg;
    logic [7:0]  tx_reg;
    logic [15:0] rd_word_reg;
    logic [1:0]  byte_idx_reg;
    logic        rw_reg;
    logic [7:0]  wr_hi_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= ST_IDLE;
            bit_cnt_reg  <= 4'h0;
            shift_reg    <= 8'h00;
            tx_reg       <= 8'h00;
            rd_word_reg  <= 16'h0000;
            byte_idx_reg <= 2'h0;
            rw_reg       <= 1'b0;
            wr_hi_reg    <= 8'h00;
            ptr_reg      <= 8'h00;
            sda_oe       <= 1'b0;
            wr_pulse_reg <= 1'b0;
            wr_word_reg  <= 16'h0000;
        end else begin
            wr_pulse_reg <= 1'b0;
            if (bus_start) begin
                // Pointer is deliberately left alone here
                state_reg   <= ST_ADDR; // R4
                bit_cnt_reg <= 4'h0;
                sda_oe      <= 1'b0;
            end else if (bus_stop) begin
                state_reg <= ST_IDLE;
                sda_oe    <= 1'b0;
            end else if (scl_rise) begin
                case (state_reg)
                    ST_ADDR, ST_WBYTE: begin
                        shift_reg   <= {shift_reg[6:0], sda_sync[1]};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    ST_RACK: begin
                        if (sda_sync[1]) begin
                            state_reg <= ST_IDLE; // R1
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state_reg)
                    ST_ADDR: begin
                        if (bit_cnt_reg == 4'h8) begin
                            if (shift_reg[7:1] == DEV_ADDR) begin
                                state_reg    <= ST_AACK;
                                sda_oe       <= 1'b1;
                                rw_reg       <= shift_reg[0];
                                byte_idx_reg <= 2'h0;
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        bit_cnt_reg <= 4'h1;
                        if (rw_reg) begin
                            // Word is frozen for the whole read so both bytes match
                            rd_word_reg  <= rd_now; // R15
                            tx_reg       <= {rd_now[14:8], 1'b0};
                            sda_oe       <= ~rd_now[15];
                            byte_idx_reg <= 2'h1;
                            state_reg    <= ST_RBYTE;
                        end else begin
                            sda_oe      <= 1'b0;
                            bit_cnt_reg <= 4'h0;
                            state_reg   <= ST_WBYTE;
                        end
                    end
                    ST_WBYTE: begin
                        if (bit_cnt_reg == 4'h8) begin
                            state_reg <= ST_WACK;
                            sda_oe    <= 1'b1;
                            case (byte_idx_reg)
                                2'h0:    ptr_reg <= shift_reg;
                                2'h1:    wr_hi_reg <= shift_reg;
                                default: begin
                                    wr_pulse_reg <= 1'b1;
                                    wr_word_reg  <= {wr_hi_reg, shift_reg};
                                end
                            endcase
                        end
                    end
                    ST_WACK: begin
                        sda_oe       <= 1'b0;
                        bit_cnt_reg  <= 4'h0;
                        state_reg    <= ST_WBYTE;
                        byte_idx_reg <= (byte_idx_reg == 2'h2) ? 2'h1 : byte_idx_reg + 2'h1;
                    end
                    ST_RBYTE: begin
                        if (bit_cnt_reg == 4'h8) begin
                            sda_oe    <= 1'b0;
                            state_reg <= ST_RACK;
                        end else begin
                            sda_oe      <= ~tx_reg[7];
                            tx_reg      <= {tx_reg[6:0], 1'b0};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                    ST_RACK: begin
                        // Host acknowledged, send the other byte of the word
                        bit_cnt_reg  <= 4'h1;
                        state_reg    <= ST_RBYTE;
                        byte_idx_reg <= (byte_idx_reg == 2'h1) ? 2'h2 : 2'h1;
                        if (byte_idx_reg == 2'h1) begin
                            sda_oe <= ~rd_word_reg[7];
                            tx_reg <= {rd_word_reg[6:0], 1'b0};
                        end else begin
                            sda_oe <= ~rd_word_reg[15];
                            tx_reg <= {rd_word_reg[14:8], 1'b0};
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Open-drain line: only ever pulled low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // Register writes, committed after the low data byte
    logic [15:0] cfg_next;
    always_comb begin
        cfg_next = (cfg_reg & ~CFG_WMASK) | (wr_word_reg & CFG_WMASK);
        cfg_next[CFG_SHDN_BIT] = wr_word_reg[CFG_SHDN_BIT] &&
                                 (shutdown || !locked); // R13 R14
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg   <= CFG_RESET; // R12
            upper_reg <= 16'h0000;
            lower_reg <= 16'h0000;
            crit_reg  <= 16'h0000;
            res_reg   <= RES_RESET; // R8
        end else if (wr_pulse_reg) begin
            case (ptr_reg)
                PTR_CFG: cfg_reg <= cfg_next; // R11 R12
                PTR_UPPER: if (!locked) upper_reg <= wr_word_reg & LIM_MASK; // R19
                PTR_LOWER: if (!locked) lower_reg <= wr_word_reg & LIM_MASK; // R19
                PTR_CRIT:  if (!locked) crit_reg <= wr_word_reg & LIM_MASK; // R19
                PTR_RES:   if (shutdown) res_reg <= wr_word_reg[1:0]; // R10 R20
                default: begin
                    // Identity words and unmapped pointers keep their contents
                end // R21
            endcase
        end
    end

    // Conversion period follows the active resolution code
    function automatic logic [TIMER_W-1:0] conv_cycles(input logic [1:0] code);
        logic [TIMER_W-1:0] c;
        c = TIMER_W'(CONV1_CYC);
        case (code)
            2'h0:    c = TIMER_W'(CONV0_CYC);
            2'h1:    c = TIMER_W'(CONV1_CYC);
            2'h2:    c = TIMER_W'(CONV2_CYC);
            default: c = TIMER_W'(CONV3_CYC);
        endcase
        return c;
    endfunction : conv_cycles

    // Step mask drops the fraction bits the chosen resolution does not carry
    function automatic logic [TEMP_W-1:0] step_mask(input logic [1:0] code);
        logic [TEMP_W-1:0] m;
        m = {TEMP_W{1'b1}};
        case (code)
            2'h0:    m = 13'h1FF8;
            2'h1:    m = 13'h1FFC;
            2'h2:    m = 13'h1FFE;
            default: m = 13'h1FFF;
        endcase
        return m;
    endfunction : step_mask

    // Conversion timer; held cleared in shutdown so a fresh period follows exit
    logic [TIMER_W-1:0] conv_cnt_reg;
    logic               conv_done;
    assign conv_done = !shutdown && (conv_cnt_reg == conv_cycles(res_reg) - 1'b1);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_cnt_reg <= '0;
            amb_reg      <= 13'h0000;
            valid_reg    <= 1'b0;
        end else if (shutdown) begin
            conv_cnt_reg <= '0; // R11
            valid_reg    <= 1'b0; // R16 R17
        end else if (conv_done) begin
            conv_cnt_reg <= '0; // R8
            amb_reg      <= temp_s2 & step_mask(res_reg); // R7 R3
            valid_reg    <= 1'b1; // R17
        end else begin
            conv_cnt_reg <= conv_cnt_reg + 1'b1;
        end
    end

    // Event output in comparator form, gated by enable, shutdown and fresh result
    assign event_active = valid_reg && !shutdown && cfg_reg[CFG_EVT_EN] &&
                          (flag_crit || flag_upper || flag_lower); // R16 R17
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            event_out   <= 1'b1;
            sampling_en <= 1'b1;
        end else begin
            event_out   <= cfg_reg[CFG_EVT_POL] ? event_active : !event_active;
            sampling_en <= !shutdown; // R11
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence wr_cfg_s;
        wr_pulse_reg && ptr_reg == PTR_CFG;
    endsequence

    shdn_lock_refuse_a: assert property ( // R13
        wr_cfg_s ##0 (locked && !shutdown) |=> !shutdown)
        else $error("shutdown set while locked");
    shdn_clear_ok_a: assert property ( // R14
        wr_cfg_s ##0 !wr_word_reg[CFG_SHDN_BIT] |=> !shutdown)
        else $error("shutdown not cleared");
    res_hold_run_a: assert property (!shutdown |=> $stable(res_reg)) // R10
        else $error("resolution changed outside shutdown");
    res_write_a: assert property ( // R20
        wr_pulse_reg && ptr_reg == PTR_RES && shutdown |=> res_reg == $past(wr_word_reg[1:0]))
        else $error("resolution not written");
    limit_lock_a: assert property ( // R19
        locked |=> $stable(upper_reg) && $stable(crit_reg) && $stable(lower_reg))
        else $error("limit changed while locked");
    // Deasserted level is the inverse of the polarity bit one cycle back
    alert_shdn_a: assert property ( // R16
        shutdown ##1 shutdown |=> event_out == !$past(cfg_reg[CFG_EVT_POL]))
        else $error("alert asserted in shutdown");
    alert_wait_a: assert property ($fell(shutdown) |-> !valid_reg ##1 !valid_reg) // R17
        else $error("alert allowed before conversion");
    cap_mirror_a: assert property (cap_now[4:3] == res_reg) // R18
        else $error("capability does not mirror resolution");
    ptr_keep_a: assert property (bus_start |=> ptr_reg == $past(ptr_reg)) // R4
        else $error("pointer lost at start");
    sample_stop_a: assert property (shutdown |=> conv_cnt_reg == '0 && !sampling_en) // R11
        else $error("sampling continues in shutdown");
endmodule : tsrs_core

// >>> tb/tsrs_host_model.sv
// Two-wire bus controller model driving the sensor's serial pins
module tsrs_host_model #(
    parameter logic [6:0] ADDR = 7'h18
) (
    input  wire logic        clk,
    input  wire logic        sda,
    output logic             scl,
    output logic             sda_low,
    output logic             rd_done,
    output logic [15:0]      rd_word,
    output int               nacks
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus idle: both lines released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        rd_done = 1'b0;
        rd_word = 16'h0000;
        nacks = 0;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w
    // Start or repeated start; SDA released while SCL is low, then pulled low while SCL is high
    task automatic start();
        sda_low = 1'b0;
        w(5);
        scl = 1'b1;
        w(10);
        sda_low = 1'b1;
        w(10);
        scl = 1'b0;
        w(5);
    endtask : start
    task automatic stop();
        sda_low = 1'b1;
        w(5);
        scl = 1'b1;
        w(10);
        sda_low = 1'b0;
        w(10);
    endtask : stop
    // One bit cell, wire sampled mid high phase
    task automatic bit_cell(input logic b, output logic s);
        sda_low = !b;
        w(5);
        scl = 1'b1;
        w(5);
        s = sda;
        w(5);
        scl = 1'b0;
        w(5);
    endtask : bit_cell
    task automatic put_byte(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cell(d[i], s);
        bit_cell(1'b1, s);
        if (s) nacks++;
    endtask : put_byte
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cell(1'b1, d[i]);
        bit_cell(last, s);
    endtask : get_byte
    task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
        start();
        put_byte({ADDR, 1'b0});
        put_byte(ptr);
        put_byte(d[15:8]);
        put_byte(d[7:0]);
        stop();
    endtask : wr
    // Word read; without set_ptr the retained pointer is used
    task automatic rd(input logic set_ptr, input logic [7:0] ptr);
        if (set_ptr) begin
            start();
            put_byte({ADDR, 1'b0});
            put_byte(ptr);
        end
        start();
        put_byte({ADDR, 1'b1});
        get_byte(1'b0, rd_word[15:8]);
        get_byte(1'b1, rd_word[7:0]);
        stop();
        rd_done = 1'b1;
        w(1);
        rd_done = 1'b0;
    endtask : rd
endmodule : tsrs_host_model

// >>> tb/tb_temp_sensor_id_resolution_shutdown.sv
// Self-checking bench for the sensor register bank
module tb_temp_sensor_id_resolution_shutdown import tsrs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MAKER = 16'h1A2B; // Arbitrary value
    logic              clk, rst_n, scl, sda, host_low, sda_out, sda_oe;
    logic              event_out, sampling_en, rd_done;
    logic [TEMP_W-1:0] temp_code;
    logic [15:0]       rd_word, r;
    logic [15:0]       exp_q[$];
    string             name_q[$];
    int                mismatches, checks, nacks;
    logic [31:0]       seed = 32'h0000000F;
    // Open-drain wire with pull-up
    assign sda = !((sda_oe & !sda_out) | host_low);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    tsrs_core #(.MAKER_ID(MAKER), .CONV0_CYC(20), .CONV1_CYC(40), .CONV2_CYC(80),
        .CONV3_CYC(160)) i_tsrs_core (.clk(clk), .rst_n(rst_n), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .temp_code(temp_code),
        .event_out(event_out), .sampling_en(sampling_en));
    tsrs_host_model i_tsrs_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low),
        .rd_done(rd_done), .rd_word(rd_word), .nacks(nacks));
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : rnd
    // Ambient word: flags against zero limits, value masked to the step
    function automatic logic [15:0] amb(input logic [12:0] t, input logic [1:0] c);
        logic [12:0] m;
        m = t & (13'h1FFF << (2'h3 - c));
        return {!m[12], !m[12] && (m != 13'h0000), m[12], m};
    endfunction : amb
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic chk_pin(input string what, input logic e, input logic g);
        chk(what, {15'h0000, e}, {15'h0000, g});
    endtask : chk_pin
    task automatic rd_exp(input logic sp, input logic [7:0] p, input logic [15:0] e,
                          input string n);
        exp_q.push_back(e);
        name_q.push_back(n);
        i_tsrs_host_model.rd(sp, p);
    endtask : rd_exp
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        i_tsrs_host_model.wr(p, d);
    endtask : wr
    task automatic done(input string n);
        $display("test %s done", n);
    endtask : done
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    // Oldest note is matched against each finished read
    always @(posedge rd_done) begin
        chk(name_q.pop_front(), exp_q.pop_front(), rd_word);
    end
    // Watchdog: about 2.4 times the expected run length
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        summarize();
    end
    initial begin
        rst_n = 1'b0;
        temp_code = 13'h0000;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        rd_exp(1'b1, PTR_RES, 16'h0001, "resolution");
        rd_exp(1'b1, PTR_CAP, 16'h00EF, "capability");
        rd_exp(1'b1, PTR_MAKER, MAKER, "maker");
        rd_exp(1'b1, PTR_PART, 16'h5A11, "part");
        done("reset values");
        // Identity writes swallowed; later reads reuse the pointer
        wr(PTR_PART, rnd());
        rd_exp(1'b0, 8'h00, 16'h5A11, "part after write");
        wr(PTR_MAKER, rnd());
        rd_exp(1'b0, 8'h00, MAKER, "maker after write");
        rd_exp(1'b0, 8'h00, MAKER, "maker reread");
        wr(PTR_RES, 16'h0003);
        rd_exp(1'b0, 8'h00, 16'h0001, "resolution while running");
        done("identity and pointer");
        // Shutdown first, then every resolution code
        wr(PTR_CFG, 16'h0100);
        chk_pin("sampling in shutdown", 1'b0, sampling_en);
        for (int c = 0; c < 4; c++) begin
            r = rnd();
            wr(PTR_RES, {r[15:2], c[1:0]});
            rd_exp(1'b0, 8'h00, {14'h0000, c[1:0]}, "resolution code");
            rd_exp(1'b1, PTR_CAP, CAP_BASE | {11'h000, c[1:0], 3'h0}, "cap code");
        end
        chk_pin("sampling held off", 1'b0, sampling_en);
        wr(PTR_CFG, 16'h01C0);
        wr(PTR_CFG, 16'h00C0);
        chk_pin("sampling after locked clear", 1'b1, sampling_en);
        wr(PTR_CFG, 16'h01C0);
        chk_pin("sampling after locked set", 1'b1, sampling_en);
        wr(PTR_UPPER, 16'h0FFC);
        rd_exp(1'b0, 8'h00, 16'h0000, "upper limit locked");
        wr(PTR_CFG, 16'h0000);
        done("shutdown and locks");
        // Every step code in turn, sign alternating; finest step left active
        for (int k = 0; k < 4; k++) begin
            r = rnd();
            wr(PTR_CFG, 16'h0100);
            wr(PTR_RES, {r[15:2], k[1:0]});
            wr(PTR_CFG, 16'h0000);
            temp_code = {k[0], r[11:0]};
            repeat (400) @(negedge clk);
            rd_exp(1'b1, PTR_AMB, amb(temp_code, k[1:0]), "ambient");
        end
        done("ambient");
        // Alert released in shutdown and held one conversion after wake
        temp_code = 13'h0190;
        wr(PTR_CFG, 16'h0008);
        repeat (400) @(negedge clk);
        chk_pin("event active", 1'b0, event_out);
        wr(PTR_CFG, 16'h0108);
        chk_pin("event in shutdown", 1'b1, event_out);
        repeat (300) @(negedge clk);
        chk_pin("event held off", 1'b1, event_out);
        wr(PTR_CFG, 16'h0008);
        chk_pin("event after wake", 1'b1, event_out);
        repeat (250) @(negedge clk);
        chk_pin("event after conversion", 1'b0, event_out);
        chk("acknowledges", 16'h0000, nacks[15:0]);
        done("alert");
        summarize();
    end
endmodule : tb_temp_sensor_id_resolution_shutdown
